//--- rtl/tsp_defines.svh
// register offsets, field positions, reset values and sizes of the stamp block
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

`define TSP_ADDR_W          4
`define TSP_OFS_CONTROL     4'h0
`define TSP_OFS_LOCAL_LAT   4'h1
`define TSP_OFS_LINK_DELAY  4'h2
`define TSP_OFS_ASYMMETRY   4'h3
`define TSP_OFS_WORD_FIRST  4'h8
`define TSP_OFS_WORD_LAST   4'he

`define TSP_CTL_SIG_LO      0
`define TSP_CTL_SIG_HI      4
`define TSP_CTL_SHORT       5
`define TSP_CTL_THR_LO      6
`define TSP_CTL_THR_HI      9
`define TSP_CTL_LVL_MASK    10
`define TSP_CTL_SERIAL      11
`define TSP_CTL_OVF_CLR     12
`define TSP_CTL_LVL_LO      16
`define TSP_CTL_LVL_HI      19
`define TSP_CTL_OVF         20

`define TSP_CONTROL_RESET   32'h0000_0010
`define TSP_EMPTY_BIT       31
`define TSP_FLAG_HI         30
`define TSP_FLAG_LO         28

`define TSP_WORD_BYTES      5'h1a
`define TSP_SIG_MAX         5'h10
`define TSP_TS_BYTES_FULL   5'h0a
`define TSP_TS_BYTES_SHORT  5'h04
`define TSP_FLAGS_FULL      3'h7
`define TSP_FIFO_DEPTH      8
`define TSP_LVL_W           4
`define TSP_FRAC_BITS       16

`endif

//--- rtl/tsp_pkg.sv
// types shared by the stamp processor and egress stamp fifo
package tsp_pkg;
  typedef logic [207:0] tsp_word_t;
  typedef logic [63:0]  tsp_time_t;
  typedef enum logic [1:0]
  {
    FLUSH_IDLE  = 2'b01,
    FLUSH_ARMED = 2'b10
  } tsp_flush_e;
endpackage

//--- rtl/tsp_stamp_block.sv
// stamp processor with latency correction and egress stamp fifo with packing
`include "tsp_defines.svh"

// What this block does
// - ingress corrected time is raw time minus fixed latency minus pipeline delay.
// - egress corrected time is raw time plus fixed latency plus pipeline delay.
// - output is either corrected time snapshot or signed 64-bit correction.
// - also give corrected time in nanoseconds, and that plus link delay.
// - link delay is added into the correction value produced for event messages.
// - asymmetry is 32-bit signed, low sixteen bits fractional nanoseconds.
// - add-asymmetry control adds the sign-extended asymmetry to the correction.
// - subtract-asymmetry control subtracts the sign-extended asymmetry from it.
// - shadow copies of latency, link delay and asymmetry guard running calculations.
// - only event messages get correction updates; follow-ups pass unchanged.
// - the stamp fifo exists only for egress stamps.
// - storing an entry raises an event; overflow raises a separate event.
// - only configured signature bytes stored; entries packed end to end.
// - full entry is 208 bits: 128 signature plus 80 stamp bits.
// - with no signature an entry is 10 bytes, or 4 in short mode.
// - packing register goes into the fifo once it holds 26 bytes.
// - head readable as seven words; first has empty at bit 31, 16 data bits.
// - each read of the seventh word pops one fifo word while serial output is disabled.
// - draining to empty flushes a partly filled packing register.
// - 3-bit flag: 000 partial, 001-110 entries starting, 111 fully packed.
// - maskable event when level reaches threshold; level readable.
// - on overflow writes are inhibited, entries dropped, contents still readable.
// - with serial output enabled, fifo register reads are invalid.
module tsp_stamp_block
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   ce_in,
  input  wire logic                   calc_valid_in,
  input  wire logic                   calc_egress_in,
  input  wire logic                   calc_event_in,
  input  wire logic                   calc_corr_mode_in,
  input  wire logic                   add_asym_in,
  input  wire logic                   sub_asym_in,
  input  wire tsp_pkg::tsp_time_t     raw_time_in,
  input  wire logic [31:0]            pipe_delay_in,
  input  wire tsp_pkg::tsp_time_t     correction_in,
  input  wire logic                   stamp_push_in,
  input  wire logic [79:0]            stamp_data_in,
  input  wire logic [127:0]           signature_in,
  input  wire logic [`TSP_ADDR_W-1:0] reg_addr_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  input  wire logic [31:0]            reg_wdata_in,
  output logic [31:0]                 reg_rdata_out,
  output logic                        result_valid_out,
  output tsp_pkg::tsp_time_t          result_out,
  output logic [47:0]                 corrected_time_nanosec_out,
  output logic [47:0]                 corrected_time_nanosec_peer_out,
  output logic                        stamp_stored_irq_out,
  output logic                        overflow_irq_out,
  output logic                        level_irq_out
);

  // software registers
  logic [31:0]               ts_fifo_control;
  logic [31:0]               local_latency;
  logic [31:0]               link_delay;
  logic [31:0]               delay_asymmetry_value;
  // shadow copies used by the calculation
  logic [31:0]               shadow_latency;
  logic [31:0]               shadow_link;
  logic [31:0]               shadow_asym;
  // fifo storage and pointers
  tsp_pkg::tsp_word_t        fifo_mem [`TSP_FIFO_DEPTH];
  logic [2:0]                fifo_flags [`TSP_FIFO_DEPTH];
  logic [2:0]                rd_ptr;
  logic [2:0]                wr_ptr;
  logic [`TSP_LVL_W-1:0]     fifo_fill_level;
  logic                      overflow_flag;
  // packing register
  tsp_pkg::tsp_word_t        pack_reg;
  logic [4:0]                pack_cnt;
  logic [2:0]                pack_starts;
  tsp_pkg::tsp_flush_e       flush_state;
  // combinational
  logic                      fifo_empty_flag;
  logic                      fifo_full;
  logic                      pop;
  logic                      fifo_wr;
  tsp_pkg::tsp_word_t        fifo_wdata;
  logic [2:0]                fifo_wflags;
  logic                      accept;
  logic                      drop;
  logic                      flush_go;
  tsp_pkg::tsp_word_t        next_pack;
  logic [4:0]                next_pack_cnt;
  logic [2:0]                next_pack_starts;
  logic [4:0]                signature_byte_count;
  logic                      short_stamp_mode;
  logic                      serial_stamp_out_enable;
  logic [`TSP_LVL_W-1:0]     fifo_level_threshold;
  logic [4:0]                ts_len;
  logic [4:0]                ent_len;
  logic [5:0]                fill_sum;
  tsp_pkg::tsp_word_t        entry;
  logic [415:0]              combined;
  logic [31:0]               head_words [7];
  tsp_pkg::tsp_time_t        active_time;
  tsp_pkg::tsp_time_t        new_corr;
  tsp_pkg::tsp_time_t        asym_ext;
  tsp_pkg::tsp_time_t        fixed_sum;

  // keeps the low n bytes of a packed value and zeroes the rest
  function automatic tsp_pkg::tsp_word_t keep_bytes(input tsp_pkg::tsp_word_t v,
                                                    input logic [4:0] n);
    tsp_pkg::tsp_word_t r;
    r = v;
    for (int i = 0; i < 26; i++)
    begin
      if (5'(i) >= n)
        r[i*8 +: 8] = 8'h00;
    end
    return r;
  endfunction

  // scales a plain nanosecond register into the fractional time format
  function automatic tsp_pkg::tsp_time_t to_scaled(input logic [31:0] ns);
    return {16'h0000, ns, 16'h0000};
  endfunction

  // control fields
  assign signature_byte_count    = (ts_fifo_control[`TSP_CTL_SIG_HI:`TSP_CTL_SIG_LO]
                                    > `TSP_SIG_MAX) ? `TSP_SIG_MAX
                                   : ts_fifo_control[`TSP_CTL_SIG_HI:`TSP_CTL_SIG_LO];
  assign short_stamp_mode        = ts_fifo_control[`TSP_CTL_SHORT];
  assign serial_stamp_out_enable = ts_fifo_control[`TSP_CTL_SERIAL];
  assign fifo_level_threshold    = ts_fifo_control[`TSP_CTL_THR_HI:`TSP_CTL_THR_LO];

  // register writes; the fifo words are read-only
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ts_fifo_control       <= `TSP_CONTROL_RESET;
      local_latency         <= 32'h0000_0000;
      link_delay            <= 32'h0000_0000;
      delay_asymmetry_value <= 32'h0000_0000;
    end
    else if (ce_in && reg_wr_in)
    begin
      if (reg_addr_in == `TSP_OFS_CONTROL)
        ts_fifo_control <= {20'h00000, reg_wdata_in[11:0]};
      else if (reg_addr_in == `TSP_OFS_LOCAL_LAT)
        local_latency <= reg_wdata_in;
      else if (reg_addr_in == `TSP_OFS_LINK_DELAY)
        link_delay <= reg_wdata_in;
      else if (reg_addr_in == `TSP_OFS_ASYMMETRY)
        delay_asymmetry_value <= reg_wdata_in;
    end
  end

  // shadows follow software only between requests
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      shadow_latency <= 32'h0000_0000;
      shadow_link    <= 32'h0000_0000;
      shadow_asym    <= 32'h0000_0000;
    end
    else if (ce_in && !calc_valid_in)
    begin
      shadow_latency <= local_latency;
      shadow_link    <= link_delay;
      shadow_asym    <= delay_asymmetry_value;
    end
  end

  // corrected time and correction value
  always_comb
  begin
    fixed_sum = to_scaled(shadow_latency) + to_scaled(pipe_delay_in);
    if (calc_egress_in)
      active_time = raw_time_in + fixed_sum;
    else
      active_time = raw_time_in - fixed_sum;
    // asymmetry keeps its fraction in the low 16 bits, sign-extended to 64
    asym_ext = {{32{shadow_asym[31]}}, shadow_asym};
    new_corr = correction_in + to_scaled(shadow_link);
    if (calc_egress_in)
      new_corr = new_corr + active_time;
    else
      new_corr = new_corr - active_time;
    if (add_asym_in)
      new_corr = new_corr + asym_ext;
    if (sub_asym_in)
      new_corr = new_corr - asym_ext;
  end

  // result stage toward the rewriter
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      result_valid_out                <= 1'b0;
      result_out                      <= 64'h0;
      corrected_time_nanosec_out      <= 48'h0;
      corrected_time_nanosec_peer_out <= 48'h0;
    end
    else if (ce_in)
    begin
      result_valid_out <= calc_valid_in;
      if (calc_valid_in)
      begin
        if (!calc_corr_mode_in)
          result_out <= active_time;
        else if (calc_event_in)
          result_out <= new_corr;
        else
          result_out <= correction_in;
        corrected_time_nanosec_out <= active_time[63:`TSP_FRAC_BITS];
        corrected_time_nanosec_peer_out <= active_time[63:`TSP_FRAC_BITS]
                                           + {16'h0000, shadow_link};
      end
    end
  end

  // fifo status; pushes come from the egress analyzer only
  assign fifo_empty_flag = (fifo_fill_level == '0);
  assign fifo_full       = (fifo_fill_level == `TSP_LVL_W'(`TSP_FIFO_DEPTH));
  assign pop = reg_rd_in && (reg_addr_in == `TSP_OFS_WORD_LAST)
               && !fifo_empty_flag && !serial_stamp_out_enable;

  // packing of one entry behind the bytes already held
  always_comb
  begin
    ts_len   = short_stamp_mode ? `TSP_TS_BYTES_SHORT : `TSP_TS_BYTES_FULL;
    ent_len  = ts_len + signature_byte_count;
    entry    = keep_bytes({128'h0, stamp_data_in}, ts_len)
               | (keep_bytes({80'h0, signature_in}, signature_byte_count)
                  << {ts_len, 3'b000});
    combined = {208'h0, pack_reg} | ({208'h0, entry} << {pack_cnt, 3'b000});
    fill_sum = {1'b0, pack_cnt} + {1'b0, ent_len};
    drop     = stamp_push_in && (overflow_flag
               || (fill_sum >= {1'b0, `TSP_WORD_BYTES} && fifo_full && !pop));
    accept   = stamp_push_in && !drop;
    flush_go = (flush_state == tsp_pkg::FLUSH_ARMED) && fifo_empty_flag
               && (pack_cnt != 5'h00) && !stamp_push_in;
    fifo_wr          = 1'b0;
    fifo_wdata       = pack_reg;
    fifo_wflags      = pack_starts;
    next_pack        = pack_reg;
    next_pack_cnt    = pack_cnt;
    next_pack_starts = pack_starts;
    if (accept && fill_sum >= {1'b0, `TSP_WORD_BYTES})
    begin
      fifo_wr          = 1'b1;
      fifo_wdata       = combined[207:0];
      fifo_wflags      = `TSP_FLAGS_FULL;
      next_pack        = combined[415:208];
      next_pack_cnt    = 5'(fill_sum - {1'b0, `TSP_WORD_BYTES});
      next_pack_starts = 3'h0;
    end
    else if (accept)
    begin
      next_pack        = combined[207:0];
      next_pack_cnt    = fill_sum[4:0];
      next_pack_starts = pack_starts + 3'h1;
    end
    else if (flush_go)
    begin
      fifo_wr          = 1'b1;
      fifo_wflags      = pack_starts;
      next_pack        = '0;
      next_pack_cnt    = 5'h00;
      next_pack_starts = 3'h0;
    end
  end

  // packing register state
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pack_reg    <= '0;
      pack_cnt    <= 5'h00;
      pack_starts <= 3'h0;
    end
    else if (ce_in)
    begin
      pack_reg    <= next_pack;
      pack_cnt    <= next_pack_cnt;
      pack_starts <= next_pack_starts;
    end
  end

  // flush arms when a pop drains the last word
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      flush_state <= tsp_pkg::FLUSH_IDLE;
    else if (ce_in)
    begin
      case (flush_state)
        tsp_pkg::FLUSH_IDLE:
          if (pop && fifo_fill_level == `TSP_LVL_W'(1) && !fifo_wr)
            flush_state <= tsp_pkg::FLUSH_ARMED;
        tsp_pkg::FLUSH_ARMED:
          if (flush_go || !fifo_empty_flag || pack_cnt == 5'h00)
            flush_state <= tsp_pkg::FLUSH_IDLE;
        default:
          flush_state <= tsp_pkg::FLUSH_IDLE;
      endcase
    end
  end

  // fifo storage, not reset
  always_ff @(posedge clk_in)
  begin
    if (ce_in && fifo_wr)
    begin
      fifo_mem[wr_ptr]   <= fifo_wdata;
      fifo_flags[wr_ptr] <= fifo_wflags;
    end
  end

  // pointers and level
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rd_ptr          <= 3'h0;
      wr_ptr          <= 3'h0;
      fifo_fill_level <= '0;
    end
    else if (ce_in)
    begin
      if (fifo_wr)
        wr_ptr <= wr_ptr + 3'h1;
      if (pop)
        rd_ptr <= rd_ptr + 3'h1;
      if (fifo_wr && !pop)
        fifo_fill_level <= fifo_fill_level + `TSP_LVL_W'(1);
      else if (pop && !fifo_wr)
        fifo_fill_level <= fifo_fill_level - `TSP_LVL_W'(1);
    end
  end

  // sticky overflow; a drop wins over a clear
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      overflow_flag <= 1'b0;
    else if (ce_in)
    begin
      if (drop)
        overflow_flag <= 1'b1;
      else if (reg_wr_in && reg_addr_in == `TSP_OFS_CONTROL
               && reg_wdata_in[`TSP_CTL_OVF_CLR])
        overflow_flag <= 1'b0;
    end
  end

  // event outputs
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      stamp_stored_irq_out <= 1'b0;
      overflow_irq_out     <= 1'b0;
      level_irq_out        <= 1'b0;
    end
    else if (ce_in)
    begin
      stamp_stored_irq_out <= accept;
      overflow_irq_out     <= overflow_flag || drop;
      level_irq_out        <= ts_fifo_control[`TSP_CTL_LVL_MASK]
                              && (fifo_fill_level >= fifo_level_threshold)
                              && (fifo_level_threshold != '0);
    end
  end

  // head word split into seven readable words
  assign head_words[0] = {fifo_empty_flag, fifo_flags[rd_ptr], 12'h000,
                          fifo_mem[rd_ptr][15:0]};
  genvar gi;
  generate
    for (gi = 1; gi < 7; gi++)
    begin : g_words
      assign head_words[gi] = fifo_mem[rd_ptr][16 + (gi-1)*32 +: 32];
    end
  endgenerate

  // read data, one cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (ce_in && reg_rd_in)
    begin
      if (reg_addr_in == `TSP_OFS_CONTROL)
        reg_rdata_out <= {11'h000, overflow_flag, fifo_fill_level,
                          ts_fifo_control[15:0]};
      else if (reg_addr_in == `TSP_OFS_LOCAL_LAT)
        reg_rdata_out <= local_latency;
      else if (reg_addr_in == `TSP_OFS_LINK_DELAY)
        reg_rdata_out <= link_delay;
      else if (reg_addr_in == `TSP_OFS_ASYMMETRY)
        reg_rdata_out <= delay_asymmetry_value;
      else if (serial_stamp_out_enable && reg_addr_in >= `TSP_OFS_WORD_FIRST
               && reg_addr_in <= `TSP_OFS_WORD_LAST)
        reg_rdata_out <= 32'h0000_0000;
      else if (reg_addr_in >= `TSP_OFS_WORD_FIRST && reg_addr_in <= `TSP_OFS_WORD_LAST)
      begin
        if (fifo_empty_flag)
          reg_rdata_out <= 32'h8000_0000;       // only the empty flag is meaningful
        else
          reg_rdata_out <= head_words[3'(reg_addr_in - `TSP_OFS_WORD_FIRST)];
      end
      else
        reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule

//--- dv/tsp_stamp_block_assertions.sv
// port timing checker for the stamp processor and egress stamp fifo
`include "tsp_defines.svh"
module tsp_stamp_checker
(
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire logic               ce_in,
  input wire logic               calc_valid_in,
  input wire logic               calc_event_in,
  input wire logic               calc_corr_mode_in,
  input wire tsp_pkg::tsp_time_t correction_in,
  input wire logic               stamp_push_in,
  input wire logic [3:0]         reg_addr_in,
  input wire logic               reg_wr_in,
  input wire logic               reg_rd_in,
  input wire logic [31:0]        reg_wdata_in,
  input wire logic [31:0]        reg_rdata_out,
  input wire logic               result_valid_out,
  input wire tsp_pkg::tsp_time_t result_out,
  input wire logic [47:0]        corrected_time_nanosec_out,
  input wire logic [47:0]        corrected_time_nanosec_peer_out,
  input wire logic               stamp_stored_irq_out,
  input wire logic               overflow_irq_out,
  input wire logic               level_irq_out
);
  logic        mask_q;
  logic        serial_q;
  logic [3:0]  thr_q;
  logic        clr_q;
  logic [31:0] link_q;
  logic [31:0] link_sh;
  logic        ctl_wr;
  logic        clr_now;
  logic        fifo_rd;
  logic        follow;
  logic [47:0] peer_diff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // decoded register port events
  assign ctl_wr    = ce_in && reg_wr_in && reg_addr_in == `TSP_OFS_CONTROL;
  assign clr_now   = ctl_wr && reg_wdata_in[`TSP_CTL_OVF_CLR];
  assign fifo_rd   = ce_in && reg_rd_in && reg_addr_in >= `TSP_OFS_WORD_FIRST
                     && reg_addr_in <= `TSP_OFS_WORD_LAST;
  assign follow    = ce_in && calc_valid_in && calc_corr_mode_in && !calc_event_in;
  assign peer_diff = corrected_time_nanosec_peer_out - corrected_time_nanosec_out;

  // control mirror; events lag a write by one edge
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mask_q   <= 1'b0;
      serial_q <= 1'b0;
      thr_q    <= 4'h0;
      clr_q    <= 1'b0;
    end
    else if (ce_in)
    begin
      clr_q <= clr_now;
      if (ctl_wr)
      begin
        mask_q   <= reg_wdata_in[`TSP_CTL_LVL_MASK];
        serial_q <= reg_wdata_in[`TSP_CTL_SERIAL];
        thr_q    <= reg_wdata_in[`TSP_CTL_THR_HI:`TSP_CTL_THR_LO];
      end
    end
  end

  // link delay and its shadow
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      link_q  <= 32'h0;
      link_sh <= 32'h0;
    end
    else if (ce_in)
    begin
      if (reg_wr_in && reg_addr_in == `TSP_OFS_LINK_DELAY)
        link_q <= reg_wdata_in;
      if (!calc_valid_in)
        link_sh <= link_q;
    end
  end

  a_result_timing: assert property (calc_valid_in && ce_in |=> result_valid_out)
    else $error("result valid missing");
  a_result_cause: assert property (result_valid_out |-> $past(calc_valid_in && ce_in))
    else $error("stray result valid");
  a_peer_link: assert property (result_valid_out |-> peer_diff == 48'($past(link_sh)))
    else $error("peer time wrong");
  a_followup_pass: assert property (follow |=> result_out == $past(correction_in))
    else $error("follow up altered");
  a_stored_cause: assert property (stamp_stored_irq_out |-> $past(stamp_push_in && ce_in))
    else $error("stray stored event");
  a_level_cause: assert property (level_irq_out |->
    (mask_q || $past(mask_q)) && (thr_q != 4'h0 || $past(thr_q) != 4'h0))
    else $error("stray level event");
  a_ovf_sticky: assert property (overflow_irq_out && !clr_now && !clr_q |=> overflow_irq_out)
    else $error("overflow lost");
  a_serial_zero: assert property (fifo_rd && serial_q |=> reg_rdata_out == 32'h0)
    else $error("serial read gave data");
  a_empty_word: assert property (fifo_rd && reg_addr_in == `TSP_OFS_WORD_FIRST
    ##1 reg_rdata_out[`TSP_EMPTY_BIT] |-> reg_rdata_out[30:0] == 31'h0)
    else $error("empty word has data");
  a_rdata_stands: assert property (!$past(reg_rd_in && ce_in) |-> $stable(reg_rdata_out))
    else $error("read data moved");

  c_overflow: cover property ($rose(overflow_irq_out));
  c_level: cover property ($rose(level_irq_out));
  c_followup: cover property (follow ##1 result_valid_out);
endmodule

bind tsp_stamp_block tsp_stamp_checker chk_i (.*);

//--- dv/tsp_feed_model.sv
// analyzer side model that offers stamp and signature entries to the packer
module tsp_feed_model
(
  input  wire logic     clk_in,
  output logic          push_out,
  output logic [79:0]   stamp_out,
  output logic [127:0]  sig_out
);
  // lines idle at time zero
  initial
  begin
    push_out  = 1'b0;
    stamp_out = 80'h0;
    sig_out   = 128'h0;
  end

  // byte j of entry k is {k, j}; signature bytes inverted
  task automatic push(input logic [3:0] k);
    @(negedge clk_in);
    for (int j = 0; j < 16; j++)
    begin
      if (j < 10)
        stamp_out[8*j +: 8] = {k, 4'(j)};
      sig_out[8*j +: 8] = ~{k, 4'(j)};
    end
    push_out = 1'b1;
    @(negedge clk_in);
    push_out  = 1'b0;
    // invert released lines against late samples
    stamp_out = ~stamp_out;
    sig_out   = ~sig_out;
  endtask
endmodule

//--- dv/test_tsp_stamp_block.sv
// self-checking bench for the stamp processor and egress stamp fifo
`include "tsp_defines.svh"
module test_tsp_stamp_block;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ASYM = 32'hffff_8000;
  logic               clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1;
  logic               calc_valid_in = 1'b0, calc_egress_in = 1'b0, calc_event_in = 1'b0;
  logic               calc_corr_mode_in = 1'b0, add_asym_in = 1'b0, sub_asym_in = 1'b0;
  logic               reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [3:0]         reg_addr_in = 4'h0;
  logic [31:0]        reg_wdata_in = 32'h0, pipe_delay_in = 32'h7, r, reg_rdata_out;
  tsp_pkg::tsp_time_t raw_time_in = 64'h0123_4567_0000_8000, correction_in = 64'h10_0000_0000;
  tsp_pkg::tsp_time_t result_out;
  logic               stamp_push_in, result_valid_out, stamp_stored_irq_out;
  logic               overflow_irq_out, level_irq_out;
  logic [79:0]        stamp_data_in;
  logic [127:0]       signature_in;
  logic [47:0]        corrected_time_nanosec_out, corrected_time_nanosec_peer_out;
  int                 error_cnt = 0, n_checks = 0;

  always #12.5 clk_in = ~clk_in;

  tsp_stamp_block uut
  (
    .clk_in, .rst_n_in, .ce_in, .calc_valid_in, .calc_egress_in, .calc_event_in,
    .calc_corr_mode_in, .add_asym_in, .sub_asym_in, .raw_time_in, .pipe_delay_in,
    .correction_in, .stamp_push_in, .stamp_data_in, .signature_in, .reg_addr_in,
    .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .result_valid_out, .result_out,
    .corrected_time_nanosec_out, .corrected_time_nanosec_peer_out, .stamp_stored_irq_out,
    .overflow_irq_out, .level_irq_out
  );
  tsp_feed_model feed
  (
    .clk_in, .push_out(stamp_push_in), .stamp_out(stamp_data_in), .sig_out(signature_in)
  );

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // register port: one-cycle strobes
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(negedge clk_in);
    {reg_addr_in, reg_rd_in} = {a, 1'b1};
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
  endtask

  // i[0] egress, i[1] add, i[2] subtract; 0 and 1 snapshot, 8 follow up
  task automatic calc(input logic [3:0] i, input bit poke, input int lat);
    logic [63:0] d, act, e, sx;
    sx = {{32{ASYM[31]}}, ASYM};
    d = 64'(lat + 7) << 16;
    act = i[0] ? raw_time_in + d : raw_time_in - d;
    e = correction_in + (64'h5 << 16) + (i[0] ? act : -act) + (i[1] ? sx : 64'h0);
    e = i[2] ? e - sx : e;
    e = i < 4'h2 ? act : (i == 4'h8 ? correction_in : e);
    @(negedge clk_in);
    {sub_asym_in, add_asym_in, calc_egress_in} = i[2:0];
    calc_corr_mode_in = i > 4'h1;
    calc_event_in = i != 4'h8;
    calc_valid_in = 1'b1;
    // a write on the request edge must miss this calculation
    if (poke)
      {reg_addr_in, reg_wdata_in, reg_wr_in} = {`TSP_OFS_LOCAL_LAT, 32'h64, 1'b1};
    @(negedge clk_in);
    {calc_valid_in, reg_wr_in} = 2'b00;
    chk("valid", 64'h1, 64'(result_valid_out));
    chk("result", e, result_out);
    chk("nanosec", 64'(act[63:16]), 64'(corrected_time_nanosec_out));
    chk("peer", 64'(act[63:16] + 48'h5), 64'(corrected_time_nanosec_peer_out));
  endtask

  // expected byte g of the packed stream
  function automatic logic [7:0] wb(input bit full, input int g);
    int k, j;
    k = full ? g / 26 : g / 4;
    j = full ? g % 26 : g % 4;
    return j < 10 ? {4'(k), 4'(j)} : ~{4'(k), 4'(j - 10)};
  endfunction

  // reads the seven head words
  task automatic rdset(input bit full, input logic [2:0] fl, input bit whole, input int g0);
    rd(`TSP_OFS_WORD_FIRST, r);
    chk("head", 64'({1'b0, fl, wb(full, g0 + 1), wb(full, g0)}), 64'({r[31:28], r[15:0]}));
    for (int a = 1; a < 7; a++)
    begin
      rd(4'(8 + a), r);
      if (whole)
        chk("word", 64'({wb(full, g0 + 4*a + 1), wb(full, g0 + 4*a), wb(full, g0 + 4*a - 1),
            wb(full, g0 + 4*a - 2)}), 64'(r));
    end
  endtask

  // watchdog, well past the tests' span
  initial
  begin
    #125000;
    error_cnt++;
    $display("timeout");
    conclude();
  end

  initial
  begin
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    rd(`TSP_OFS_CONTROL, r);
    chk("control", 64'(`TSP_CONTROL_RESET), 64'(r));
    rd(`TSP_OFS_WORD_LAST, r);
    chk("empty read", 64'h8000_0000, 64'(r));
    wr(4'h5, 32'hffff_ffff);
    rd(4'h5, r);
    chk("unmapped", 64'h0, 64'(r));
    rd(`TSP_OFS_CONTROL, r);
    chk("level", 64'h0, 64'(r[20:16]));
    $display("test reset done");
    wr(`TSP_OFS_LOCAL_LAT, 32'h3);
    wr(`TSP_OFS_LINK_DELAY, 32'h5);
    wr(`TSP_OFS_ASYMMETRY, ASYM);
    for (int i = 0; i < 9; i++)
      calc(4'(i), 1'b0, 3);
    calc(4'h1, 1'b1, 3);
    calc(4'h1, 1'b0, 100);
    $display("test calc done");
    wr(`TSP_OFS_CONTROL, 32'h20);
    for (int k = 0; k < 7; k++)
    begin
      feed.push(4'(k));
      chk("stored", 64'h1, 64'(stamp_stored_irq_out));
    end
    rd(`TSP_OFS_CONTROL, r);
    chk("level", 64'h1, 64'(r[19:16]));
    rdset(1'b0, 3'h7, 1'b1, 0);
    repeat (2) @(negedge clk_in);
    rdset(1'b0, 3'h0, 1'b0, 26);
    rd(`TSP_OFS_WORD_FIRST, r);
    chk("drained", 64'h8000_0000, 64'(r));
    $display("test packing done");
    wr(`TSP_OFS_CONTROL, 32'h510);
    for (int k = 0; k < 9; k++)
    begin
      feed.push(4'(k));
      chk("stored", 64'(k < 8), 64'(stamp_stored_irq_out));
    end
    @(negedge clk_in);
    chk("overflow", 64'h1, 64'(overflow_irq_out));
    chk("level event", 64'h1, 64'(level_irq_out));
    rd(`TSP_OFS_CONTROL, r);
    chk("level ovf", 64'h18, 64'(r[20:16]));
    rdset(1'b1, 3'h7, 1'b1, 0);
    feed.push(4'h9);
    chk("dropped", 64'h0, 64'(stamp_stored_irq_out));
    wr(`TSP_OFS_CONTROL, 32'h1510);
    repeat (2) @(negedge clk_in);
    chk("overflow", 64'h0, 64'(overflow_irq_out));
    $display("test overflow done");
    wr(`TSP_OFS_CONTROL, 32'hd10);
    rd(`TSP_OFS_WORD_LAST, r);
    chk("serial read", 64'h0, 64'(r));
    rd(`TSP_OFS_CONTROL, r);
    chk("level kept", 64'h7, 64'(r[20:16]));
    chk("level event", 64'h1, 64'(level_irq_out));
    wr(`TSP_OFS_CONTROL, 32'h110);
    @(negedge clk_in);
    chk("masked", 64'h0, 64'(level_irq_out));
    rdset(1'b1, 3'h7, 1'b1, 26);
    $display("test serial done");
    conclude();
  end
endmodule
